// File: design/ast_top.sv
// Purpose: Async serial transceiver with Wishbone register access.
// Assumes: Pins are synchronised here; slow clock mode is outside.
// Notes: Transmit has no holding stage beyond the shifter.
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ast_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic port_d_bit2_i,
    output logic port_d_bit3_o,
    output logic port_d_bit3_oe_n_o,
    input wire logic port_d_bit3_gpio_i,
    input wire logic port_d_bit3_gpio_oe_n_i,
    output logic serial_irq_o,
    output logic port_d_bit2_sel_o
);
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_START = 4'h2,
        TX_DATA = 4'h4,
        TX_STOP = 4'h8
    } ast_tx_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } ast_rx_t;
    typedef struct packed {
        logic [31:0] dat;
        logic ack;
        logic [7:0] ctl1;
        logic [6:0] ctl2;
        logic [7:0] rxbuf;
        logic rxmsb;
        ast_tx_t txs;
        logic [3:0] txph;
        logic [3:0] txn;
        logic [10:0] txsh;
        logic txd;
        ast_rx_t rxs;
        logic [3:0] rxph;
        logic [3:0] rxn;
        logic [9:0] rxsh;
        logic [2:0] smp;
        logic s1;
        logic s2;
        logic s3;
        logic irq;
        logic p3;
        logic p3oe;
    } ast_st_t;
    ast_st_t s_r;
    ast_st_t s_nxt;
    logic pin_m;
    logic pin_s;
    logic tick;
    logic wr;
    logic rd;
    logic go;
    logic maj;
    logic [3:0] nbits;
    logic pen;
    logic par;
    logic [8:0] dbits;
    ast_tick_if tk ();
    ast_baud u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tk(tk)
    );
    assign tk.rate = s_r.ctl1[ast_pkg::C1_RATE_LO +: 3];
    assign tick = tk.tick;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_m <= 1'b1;
            pin_s <= 1'b1;
        end else begin
            pin_m <= port_d_bit2_i;
            pin_s <= pin_m;
        end
    end
    always_comb begin
        go = wb_cyc_i && wb_stb_i && !s_r.ack;
        wr = go && wb_we_i && wb_sel_i[0];
        rd = go && !wb_we_i;
        maj = (s_r.s1 & s_r.s2) | (s_r.s1 & s_r.s3) | (s_r.s2 & s_r.s3);
        dbits = 9'h000;
        par = 1'b0;
        case (s_r.ctl1[ast_pkg::C1_LEN_LO +: 2])
            ast_pkg::AST_LEN7: nbits = 4'h7;
            ast_pkg::AST_LEN8: nbits = 4'h8;
            ast_pkg::AST_LEN9: nbits = 4'h9;
            default: nbits = 4'h8;
        endcase
        pen = s_r.ctl2[ast_pkg::C2_PEN] && (nbits != 4'h9);
        s_nxt = s_r;
        s_nxt.ack = go;
        s_nxt.dat = 32'h00000000;
        if (rd) begin
            case (wb_adr_i)
                ast_pkg::ADR_RXBUF: s_nxt.dat = {24'h000000, s_r.rxbuf};
                ast_pkg::ADR_CTL1: s_nxt.dat = {24'h000000, s_r.ctl1};
                ast_pkg::ADR_CTL2: s_nxt.dat = {25'h0000000, s_r.ctl2};
                ast_pkg::ADR_MSB: s_nxt.dat = {31'h00000000, s_r.rxmsb};
                default: s_nxt.dat = 32'h00000000;
            endcase
        end
        if (rd && wb_adr_i == ast_pkg::ADR_RXBUF) begin
            s_nxt.ctl2[ast_pkg::C2_RBF] = 1'b0;
        end
        if (wr && wb_adr_i == ast_pkg::ADR_CTL1) begin
            s_nxt.ctl1 = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == ast_pkg::ADR_MSB) begin
            s_nxt.rxmsb = wb_dat_i[0];
        end
        if (wr && wb_adr_i == ast_pkg::ADR_CTL2) begin
            s_nxt.ctl2[6:5] = wb_dat_i[6:5];
            s_nxt.ctl2[4:2] = s_r.ctl2[4:2] & wb_dat_i[4:2];
        end
        // Transmit: shifted at tick/16 bit rate.
        if (s_r.txs == TX_IDLE) begin
            s_nxt.txd = 1'b1;
            if (wr && wb_adr_i == ast_pkg::ADR_RXBUF &&
                s_r.ctl1[ast_pkg::C1_TXE]) begin
                dbits = {s_r.rxmsb, wb_dat_i[7:0]};
                if (nbits == 4'h7) begin
                    dbits[8:7] = 2'b00;
                end else if (nbits == 4'h8) begin
                    dbits[8] = 1'b0;
                end
                par = ^dbits ^ !s_r.ctl2[ast_pkg::C2_EVEN];
                s_nxt.txsh = 11'h7FF;
                s_nxt.txsh[8:0] = dbits;
                if (pen) begin
                    s_nxt.txsh[nbits] = par;
                end
                s_nxt.txn = pen ? nbits + 4'h1 : nbits;
                s_nxt.ctl2[ast_pkg::C2_TBE] = 1'b0;
                s_nxt.txs = TX_START;
                s_nxt.txph = 4'h0;
            end
        end else if (tick) begin
            s_nxt.txph = s_r.txph + 4'h1;
            if (s_r.txph == 4'hF) begin
                case (s_r.txs)
                    TX_START: begin
                        s_nxt.txs = TX_DATA;
                        s_nxt.txd = s_r.txsh[0];
                        s_nxt.txsh = {1'b1, s_r.txsh[10:1]};
                        s_nxt.txn = s_r.txn - 4'h1;
                    end
                    TX_DATA: begin
                        s_nxt.txd = s_r.txsh[0];
                        s_nxt.txsh = {1'b1, s_r.txsh[10:1]};
                        s_nxt.txn = s_r.txn - 4'h1;
                        if (s_r.txn == 4'h0) begin
                            s_nxt.txs = TX_STOP;
                            s_nxt.txd = 1'b1;
                        end
                    end
                    default: begin
                        s_nxt.txs = TX_IDLE;
                        s_nxt.ctl2[ast_pkg::C2_TBE] = 1'b1;
                    end
                endcase
            end
        end
        if (s_r.txs == TX_START) begin
            s_nxt.txd = (tick && s_r.txph == 4'hF) ? s_r.txsh[0] : 1'b0;
        end
        if (!s_r.ctl1[ast_pkg::C1_TXE] && s_r.txs == TX_IDLE) begin
            s_nxt.ctl2[ast_pkg::C2_TBE] = 1'b1;
        end
        // Receive: three samples at phases 7..9.
        if (tick) begin
            s_nxt.s1 = pin_s;
            s_nxt.s2 = s_r.s1;
            s_nxt.s3 = s_r.s2;
        end
        if (!s_r.ctl1[ast_pkg::C1_RXE]) begin
            s_nxt.rxs = RX_IDLE;
        end else if (tick) begin
            s_nxt.rxph = s_r.rxph + 4'h1;
            case (s_r.rxs)
                RX_IDLE: begin
                    // falling edge sync
                    // Level detection would restart on a low stop bit.
                    if (!pin_s && s_r.s1) begin
                        s_nxt.rxs = RX_START;
                        s_nxt.rxph = 4'h1;
                    end
                end
                RX_START: begin
                    if (s_r.rxph == 4'hA) begin
                        if (!maj) begin
                            s_nxt.rxs = RX_DATA;
                            s_nxt.rxn = pen ? nbits + 4'h1 : nbits;
                        end else begin
                            s_nxt.rxs = RX_IDLE;
                        end
                    end
                end
                RX_DATA: begin
                    if (s_r.rxph == 4'hA) begin
                        s_nxt.rxsh = {maj, s_r.rxsh[9:1]};
                        s_nxt.rxn = s_r.rxn - 4'h1;
                        if (s_r.rxn == 4'h1) begin
                            s_nxt.rxs = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (s_r.rxph == 4'hA) begin
                        s_nxt.rxs = RX_IDLE;
                        dbits = 9'(s_r.rxsh >> (pen ? 4'h9 - nbits :
                            4'hA - nbits));
                        if (nbits == 4'h7) begin
                            dbits[8:7] = 2'b00;
                        end else if (nbits == 4'h8) begin
                            dbits[8] = 1'b0;
                        end
                        par = s_r.rxsh[9] ^ ^dbits;
                        s_nxt.rxbuf = dbits[7:0];
                        s_nxt.rxmsb = dbits[8];
                        if (!maj) begin
                            s_nxt.ctl2[ast_pkg::C2_FME] = 1'b1;
                        end
                        if (pen && (par != !s_r.ctl2[ast_pkg::C2_EVEN])) begin
                            s_nxt.ctl2[ast_pkg::C2_PRE] = 1'b1;
                        end
                        if (s_r.ctl2[ast_pkg::C2_RBF] && !(rd &&
                            wb_adr_i == ast_pkg::ADR_RXBUF)) begin
                            s_nxt.ctl2[ast_pkg::C2_OVE] = 1'b1;
                        end
                        s_nxt.ctl2[ast_pkg::C2_RBF] = 1'b1;
                    end
                end
                default: s_nxt.rxs = RX_IDLE;
            endcase
        end
        s_nxt.irq = (s_nxt.ctl1[ast_pkg::C1_RXE] &&
            (s_nxt.ctl2[ast_pkg::C2_RBF] || (s_nxt.ctl1[ast_pkg::C1_ERE]
            && |s_nxt.ctl2[4:2]))) || (s_nxt.ctl1[ast_pkg::C1_TXE] &&
            s_nxt.ctl2[ast_pkg::C2_TBE]);
        s_nxt.p3 = s_nxt.ctl1[ast_pkg::C1_TXE] ? s_nxt.txd :
            port_d_bit3_gpio_i;
        s_nxt.p3oe = s_nxt.ctl1[ast_pkg::C1_TXE] ? 1'b0 :
            port_d_bit3_gpio_oe_n_i;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.ctl1 <= ast_pkg::CTL1_RST;
            s_r.ctl2 <= ast_pkg::CTL2_RST | 7'h02;
            s_r.txs <= TX_IDLE;
            s_r.rxs <= RX_IDLE;
            s_r.txd <= 1'b1;
            s_r.s1 <= 1'b1;
            s_r.s2 <= 1'b1;
            s_r.s3 <= 1'b1;
            s_r.p3oe <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign serial_irq_o = s_r.irq;
    assign port_d_bit3_o = s_r.p3;
    assign port_d_bit3_oe_n_o = s_r.p3oe;
    assign port_d_bit2_sel_o = s_r.ctl1[ast_pkg::C1_RXE];
endmodule : ast_top
`default_nettype wire

// File: design/ast_pkg.sv
// Purpose: Constants and types for the async serial transceiver.
// Assumes: 100 MHz clock, classic Wishbone register access.
// Notes: Functional notes follow.
package ast_pkg;
    localparam logic [3:0] ADR_RXBUF = 4'h0;
    localparam logic [3:0] ADR_CTL1 = 4'h4;
    localparam logic [3:0] ADR_CTL2 = 4'h8;
    localparam logic [3:0] ADR_MSB = 4'hC;
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [6:0] CTL2_RST = 7'h00;
    localparam int C1_RXE = 0;
    localparam int C1_TXE = 1;
    localparam int C1_ERE = 2;
    localparam int C1_LEN_LO = 3;
    localparam int C1_RATE_LO = 5;
    localparam int C2_RBF = 0;
    localparam int C2_TBE = 1;
    localparam int C2_FME = 2;
    localparam int C2_OVE = 3;
    localparam int C2_PRE = 4;
    localparam int C2_PEN = 5;
    localparam int C2_EVEN = 6;
    localparam int CLK_HZ = 100000000;
    localparam int OVS = 16;
    localparam int BAUD_TAB [8] = '{600, 1200, 2400, 9600, 19200, 38400,
        57600, 115200};
    typedef enum logic [1:0] {
        AST_LEN7 = 2'h0,
        AST_LEN8 = 2'h1,
        AST_LEN9 = 2'h2,
        AST_LENX = 2'h3
    } ast_len_t;
endpackage : ast_pkg

// File: design/ast_tick_if.sv
// Purpose: Carries the oversample tick and rate selection.
// Assumes: One clock domain.
// Notes: Rate selection flows out, tick flows back.
`timescale 1ns/10ps
`default_nettype none
interface ast_tick_if;
    logic [2:0] rate;
    logic tick;
    modport src (input rate, output tick);
    modport dst (output rate, input tick);
endinterface : ast_tick_if
`default_nettype wire

// File: design/ast_baud.sv
// Purpose: Sixteen-times oversample tick generator.
// Assumes: 100 MHz clock.
// Notes: Divisors round down; 115200 baud is off by under one percent.
`timescale 1ns/10ps
`default_nettype none
module ast_baud (
    input wire logic clk_i,
    input wire logic rst_i,
    ast_tick_if.src tk
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } ast_baud_st_t;
    ast_baud_st_t s_r;
    ast_baud_st_t s_nxt;
    logic [15:0] lim;
    always_comb begin
        // rate divisor, slow clock mode handled outside
        lim = 16'(ast_pkg::CLK_HZ / (ast_pkg::OVS *
            ast_pkg::BAUD_TAB[tk.rate]) - 1);
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt >= lim) begin
            s_nxt.cnt = 16'h0000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign tk.tick = s_r.tick;
endmodule : ast_baud
`default_nettype wire

// File: tb/ast_checker.sv
// Purpose: Port level checks for the async serial transceiver.
// Assumes: Sees only the top ports; control one is shadowed from writes.
// Notes: Pins are registered, so pin checks wait for a settled control.
`timescale 1ns/10ps
`default_nettype none
module ast_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic port_d_bit2_i,
    input wire logic port_d_bit3_o,
    input wire logic port_d_bit3_oe_n_o,
    input wire logic port_d_bit3_gpio_i,
    input wire logic port_d_bit3_gpio_oe_n_i,
    input wire logic serial_irq_o,
    input wire logic port_d_bit2_sel_o
);
    logic take;
    logic [7:0] c1_r;
    logic [3:0] adr_r;
    logic we_r;
    logic [7:0] st_r;
    logic st_v_r;
    logic rd_ack;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_ack = wb_ack_o && !we_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c1_r <= 8'h00;
            st_v_r <= 1'h0;
        end else begin
            if (take) begin
                adr_r <= wb_adr_i;
                we_r <= wb_we_i;
            end
            if (take && wb_we_i && wb_sel_i[0] &&
                wb_adr_i == ast_pkg::ADR_CTL1) begin
                c1_r <= wb_dat_i[7:0];
            end
            // A write to control two may clear flags, so history restarts.
            if (take && wb_we_i && wb_adr_i == ast_pkg::ADR_CTL2) begin
                st_v_r <= 1'h0;
            end else if (rd_ack && adr_r == ast_pkg::ADR_CTL2) begin
                st_v_r <= 1'h1;
                st_r <= wb_dat_o[7:0];
            end
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_ack_answer: assert property (take |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ctl1_read: assert property (rd_ack
        && adr_r == ast_pkg::ADR_CTL1 |-> wb_dat_o == {24'h000000, c1_r})
        else $error("control one readback");
    chk_unmapped_zero: assert property (rd_ack && adr_r[1:0] != 2'h0
        |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
    chk_err_sticky: assert property (rd_ack
        && adr_r == ast_pkg::ADR_CTL2 && st_v_r
        |-> (wb_dat_o[4:2] & st_r[4:2]) == st_r[4:2])
        else $error("error flag cleared without a write");
    chk_tx_pin_drive: assert property (c1_r[1] && $past(c1_r[1])
        |-> !port_d_bit3_oe_n_o) else $error("transmit pin not driven");
    chk_gpio_pass: assert property (!c1_r[1] && !$past(c1_r[1])
        && !$past(rst_i) |-> port_d_bit3_o == $past(port_d_bit3_gpio_i)
        && port_d_bit3_oe_n_o == $past(port_d_bit3_gpio_oe_n_i))
        else $error("general pin not passed through");
    chk_rx_pin_sel: assert property (c1_r[0] == $past(c1_r[0])
        && !$past(rst_i) |-> port_d_bit2_sel_o == c1_r[0])
        else $error("receive pin selection wrong");
    chk_irq_off: assert property (c1_r[1:0] == 2'h0
        && $past(c1_r[1:0]) == 2'h0 |-> !serial_irq_o)
        else $error("interrupt with both functions off");
endmodule : ast_checker
`default_nettype wire

// File: tb/ast_peer.sv
// Purpose: Remote serial peer that sends and samples frames.
// Assumes: Bit period in clock cycles is given as a parameter.
// Notes: Samples at bit centres; no resynchronising within a frame.
`timescale 1ns/10ps
`default_nettype none
module ast_peer #(
    parameter int BIT = 864
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    initial line_o = 1'h1;
    task automatic hold(input logic v);
        line_o <= v;
        repeat (BIT) @(posedge clk_i);
    endtask : hold
    task automatic send(input logic [8:0] d, input int nb, input bit par,
        input logic pb, input logic sb);
        hold(1'h0);
        for (int i = 0; i < nb; i++) begin
            hold(d[i]);
        end
        if (par) begin
            hold(pb);
        end
        hold(sb);
        line_o <= 1'h1;
    endtask : send
    task automatic recv(input int nb, input bit par, output logic [8:0] d,
        output logic pb, output logic sb);
        d = 9'h000;
        pb = 1'h0;
        @(negedge line_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            repeat (BIT) @(posedge clk_i);
            d[i] = line_i;
        end
        if (par) begin
            repeat (BIT) @(posedge clk_i);
            pb = line_i;
        end
        repeat (BIT) @(posedge clk_i);
        sb = line_i;
    endtask : recv
endmodule : ast_peer
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the async serial transceiver.
// Assumes: Fastest rate code, so a frame takes about ten thousand cycles.
// Notes: Transmit pin reads high when released by the block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int BITC = ast_pkg::OVS
        * (ast_pkg::CLK_HZ / (ast_pkg::OVS * ast_pkg::BAUD_TAB[7]));
    logic clk_i, rst_i = 1'h1, wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h00000000, rdat;
    logic ack, rx_line, tx_out, tx_oe_n, irq, sel2, line3;
    logic gpio = 1'h1, gpio_oe_n = 1'h1;
    int mismatches = 0, n_checks = 0, cycles = 0;
    assign line3 = tx_oe_n ? 1'h1 : tx_out;
    ast_top u_ast_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .port_d_bit2_i(rx_line), .port_d_bit3_o(tx_out),
        .port_d_bit3_oe_n_o(tx_oe_n), .port_d_bit3_gpio_i(gpio),
        .port_d_bit3_gpio_oe_n_i(gpio_oe_n), .serial_irq_o(irq),
        .port_d_bit2_sel_o(sel2));
    ast_peer #(.BIT(BITC)) u_peer (.clk_i(clk_i), .line_i(line3),
        .line_o(rx_line));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h00000000, got}, {31'h00000000, exp});
    endtask : chk_pin
    // Called just after an edge; returns one cycle after the ack edge.
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= {24'h000000, d};
        @(posedge clk_i);
        while (ack !== 1'h1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) begin
            mismatches++;
            report_and_stop();
        end
        q = rdat;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'h0, a, 8'h00, q);
        chk_reg(q, exp);
    endtask : rd
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    // A hang costs a mismatch; the full run needs about 77500 cycles.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 100000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        logic [8:0] d, g;
        logic pb, sb;
        logic [7:0] e;
        int nb;
        void'($urandom(32'hC4C2));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(ast_pkg::ADR_CTL1, 32'h00000000);
        rd(ast_pkg::ADR_CTL2, 32'h00000002);
        wr(4'h2, 8'hFF);
        rd(4'h2, 32'h00000000);
        e = 8'($urandom) & 8'hF8;
        wr(ast_pkg::ADR_CTL1, e);
        rd(ast_pkg::ADR_CTL1, {24'h000000, e});
        wr(ast_pkg::ADR_CTL2, 8'h7F);
        rd(ast_pkg::ADR_CTL2, 32'h00000062);
        for (int i = 0; i < 4; i++) begin
            gpio <= 1'($urandom);
            gpio_oe_n <= 1'($urandom);
            repeat (3) @(posedge clk_i);
            chk_pin(tx_out, gpio);
            chk_pin(tx_oe_n, gpio_oe_n);
            chk_pin(sel2, 1'h0);
            chk_pin(irq, 1'h0);
        end
        gpio <= 1'h1;
        for (int c = 0; c < 3; c++) begin
            nb = 7 + c;
            d = 9'($urandom) & ((9'h001 << nb) - 9'h001);
            wr(ast_pkg::ADR_CTL1, {3'h7, 2'(c), 3'h2});
            wr(ast_pkg::ADR_CTL2, {1'h0, 1'(c), 6'h20});
            wr(ast_pkg::ADR_MSB, {7'h00, d[8]});
            fork
                begin
                    wr(ast_pkg::ADR_RXBUF, d[7:0]);
                    rd(ast_pkg::ADR_CTL2, {25'h0, 1'(c), 6'h20});
                end
                u_peer.recv(nb, c != 2, g, pb, sb);
            join
            chk_pin(tx_oe_n, 1'h0);
            chk_reg(32'(g), 32'(d));
            chk_pin(pb, (c == 2) ? 1'h0 : ^d ^ (c == 0));
            chk_pin(sb, 1'h1);
            repeat (BITC / 2) @(posedge clk_i);
            rd(ast_pkg::ADR_CTL2, {25'h0, 1'(c), 6'h22});
            chk_pin(irq, 1'h1);
        end
        wr(ast_pkg::ADR_CTL1, 8'hED);
        wr(ast_pkg::ADR_CTL2, 8'h60);
        chk_pin(sel2, 1'h1);
        for (int k = 0; k < 4; k++) begin
            d = 9'($urandom) & 9'h0FF;
            e = (k == 1) ? 8'h10 : (k == 2) ? 8'h04 : (k == 3) ? 8'h08 : 8'h00;
            u_peer.send(d, 8, 1'h1, ^d ^ (k == 1), k != 2);
            repeat (BITC / 2) @(posedge clk_i);
            if (k == 3) begin
                u_peer.send(d, 8, 1'h1, ^d, 1'h1);
                repeat (BITC / 2) @(posedge clk_i);
            end
            rd(ast_pkg::ADR_CTL2, {24'h000000, 8'h63 | e});
            chk_pin(irq, 1'h1);
            rd(ast_pkg::ADR_RXBUF, {24'h000000, d[7:0]});
            wr(ast_pkg::ADR_RXBUF, ~d[7:0]);
            rd(ast_pkg::ADR_RXBUF, {24'h000000, d[7:0]});
            rd(ast_pkg::ADR_CTL2, {24'h000000, 8'h62 | e});
            chk_pin(irq, e != 8'h00);
            wr(ast_pkg::ADR_CTL2, 8'h60);
            rd(ast_pkg::ADR_CTL2, 32'h00000062);
        end
        report_and_stop();
    end
endmodule : tb_top
bind ast_top ast_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_d_bit2_i(port_d_bit2_i),
    .port_d_bit3_o(port_d_bit3_o), .port_d_bit3_oe_n_o(port_d_bit3_oe_n_o),
    .port_d_bit3_gpio_i(port_d_bit3_gpio_i),
    .port_d_bit3_gpio_oe_n_i(port_d_bit3_gpio_oe_n_i),
    .serial_irq_o(serial_irq_o), .port_d_bit2_sel_o(port_d_bit2_sel_o));
`default_nettype wire
